// ---- rtl/vlc_config_regs.sv ----
// Operation
// - Delay code n means 9+n microseconds
// - Delay code resets to 0111
// - Delay register writable once, always readable
// - Receive polarity one passes, zero inverts
// - Ignore bit blocks reception, masks except 20
// - Frame start or break clears ignore
// - Frequency select scales symbol timing
// - Rate field divides clock 1,2,4,8
// - Rate field writable once after reset
// - Irq enable gates run-mode requests only
// - Request held until all sources cleared
// - Wait gate stops clocks in wait
// - Analog loopback returns drive, bus undriven
// - After analog loopback, wait idle times
// - Digital loopback ties transmit to receive
// - After digital loopback, wait idle times
// - Fast enable: receive only at 4X
// - Break clears fast enable, loads 001c
// - 4X traffic ignored when fast clear
module vlc_config_regs #(
  parameter int END_FRAME_CYCLES  = vlc_pkg::END_FRAME_CYC,
  parameter int INTERFRAME_CYCLES = vlc_pkg::INTERFRAME_CYC
) (
  input  wire logic       CLK_IN,            // System clock
  input  wire logic       RESETN_IN,         // Async reset, active low
  input  wire logic [1:0] ADDR_IN,           // Register address
  input  wire logic [7:0] WDATA_IN,          // Write data
  input  wire logic       WR_IN,             // Write strobe
  input  wire logic       RD_IN,             // Read strobe
  output logic      [7:0] RDATA_OUT,         // Read data, next cycle
  input  wire logic       RX_PIN_IN,         // Receive pin, async
  input  wire logic       TX_DIGITAL_IN,     // Digital transmit output
  input  wire logic       DRIVE_STAGE_IN,    // Drive stage echo
  output logic            DIGITAL_RX_OUT,    // Receiver input
  output logic            BUS_DRIVE_EN_OUT,  // Bus may be driven
  input  wire logic       SOF_SEEN_IN,       // Frame start pulse
  input  wire logic       BREAK_SEEN_IN,     // Break symbol pulse
  input  wire logic       FAST_SYMBOL_IN,    // 4X symbol seen pulse
  input  wire logic       BUS_IDLE_IN,       // Bus idle level
  input  wire logic [7:0] STATE_CODE_IN,     // Current state code
  input  wire logic       EVENT_PENDING_IN,  // Any request source set
  input  wire logic       CPU_WAIT_IN,       // CPU in wait mode
  input  wire logic       WAKE_REQ_IN,       // Wake-up request
  output logic            IRQ_OUT,           // Interrupt request
  output logic            CLK_RUN_OUT,       // Internal clocks enabled
  output logic            TICK_OUT,          // Link timing clock pulse
  output logic            FREQ_BINARY_OUT,   // Binary link frequency
  output logic      [4:0] DELAY_US_OUT,      // Expected delay, us
  output logic            RX_ENABLE_OUT,     // Reception allowed
  output logic            TX_ENABLE_OUT,     // Transmission allowed
  output logic            STATUS_HOLD_OUT,   // Hold status at reset
  output logic            FAST_RX_OUT,       // 4X receive only
  output logic            FAST_NOISE_OUT,    // 4X symbol as noise
  output logic            VECTOR_LOAD_OUT,   // Load state vector
  output logic     [15:0] VECTOR_VALUE_OUT   // Value to load
);

  logic [7:0]  delay_reg;
  logic [7:0]  ctl1;
  logic [7:0]  ctl2;
  logic        delay_written;
  logic        rate_written;
  logic        rx_meta;
  logic        rx_sync;
  logic [2:0]  div_cnt;
  logic [2:0]  div_max;
  logic [31:0] rx_wait;
  logic [31:0] tx_wait;
  logic        wr_delay;
  logic        wr_ctl1;
  logic        wr_ctl2;
  logic        loop_exit;
  logic        rx_pol;
  logic        irq_run;

  assign wr_delay = WR_IN && ADDR_IN == vlc_pkg::ADDR_DELAY;
  assign wr_ctl1  = WR_IN && ADDR_IN == vlc_pkg::ADDR_CTL1;
  assign wr_ctl2  = WR_IN && ADDR_IN == vlc_pkg::ADDR_CTL2;

  // Writes to the status address decode to nothing and are dropped.

  // The written flags are sticky so that a locked field stays locked
  // until the next reset, whatever software writes afterwards.
  // Delay write once
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      delay_written <= 1'b0;
      rate_written  <= 1'b0;
    end
    else
    begin
      if (wr_delay)
        delay_written <= 1'b1;
      if (wr_ctl1)
        rate_written <= 1'b1;
    end

  // Only the masked bits are storable; the rest read back as zero.
  // Delay reset code
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
      delay_reg <= vlc_pkg::DELAY_RESET;
    else if (wr_delay && !delay_written)
      delay_reg <= WDATA_IN & vlc_pkg::DELAY_WMASK;

  // Control one; the ignore bit is cleared by hardware with priority
  // over a software set in the same cycle only for the frame events.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
      ctl1 <= vlc_pkg::CTL1_RESET;
    else
    begin
      if (wr_ctl1)
      begin
        ctl1[vlc_pkg::C1_IGNORE]    <= WDATA_IN[vlc_pkg::C1_IGNORE];
        ctl1[vlc_pkg::C1_FREQ_SEL]  <= WDATA_IN[vlc_pkg::C1_FREQ_SEL];
        ctl1[vlc_pkg::C1_IRQ_EN]    <= WDATA_IN[vlc_pkg::C1_IRQ_EN];
        ctl1[vlc_pkg::C1_WAIT_GATE] <= WDATA_IN[vlc_pkg::C1_WAIT_GATE];
        if (!rate_written)
        begin
          ctl1[vlc_pkg::C1_RATE_HI] <= WDATA_IN[vlc_pkg::C1_RATE_HI];
          ctl1[vlc_pkg::C1_RATE_LO] <= WDATA_IN[vlc_pkg::C1_RATE_LO];
        end
      end
      if (SOF_SEEN_IN || BREAK_SEEN_IN)
        ctl1[vlc_pkg::C1_IGNORE] <= 1'b0;
    end

  // A break in the same cycle as a software write still clears the
  // fast enable, so the hardware event always wins.
  // Break clears fast enable
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
      ctl2 <= vlc_pkg::CTL2_RESET;
    else if (BREAK_SEEN_IN)
      ctl2 <= (wr_ctl2 ? WDATA_IN & vlc_pkg::CTL2_MASK : ctl2)
              & ~(8'h01 << vlc_pkg::C2_FAST_RX);
    else if (wr_ctl2)
      ctl2 <= WDATA_IN & vlc_pkg::CTL2_MASK;

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      VECTOR_LOAD_OUT  <= 1'b0;
      VECTOR_VALUE_OUT <= 16'h0000;
    end
    else
    begin
      VECTOR_LOAD_OUT  <= BREAK_SEEN_IN;
      VECTOR_VALUE_OUT <= vlc_pkg::VECTOR_BREAK;
    end

  // Two flops bring the receive pin into the clock domain; only the
  // second one is read by any logic.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
    end
    else
    begin
      rx_meta <= RX_PIN_IN;
      rx_sync <= rx_meta;
    end

  assign rx_pol = delay_reg[vlc_pkg::DLY_RX_POL] ? rx_sync : ~rx_sync;

  // Digital loopback takes priority over analog loopback when both
  // are set, since it isolates the controller from the transceiver.
  // Digital loopback mux
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      DIGITAL_RX_OUT   <= 1'b0;
      BUS_DRIVE_EN_OUT <= 1'b0;
    end
    else
    begin
      if (ctl2[vlc_pkg::C2_DIGITAL_LOOPBACK])
        DIGITAL_RX_OUT <= TX_DIGITAL_IN;
      else if (ctl2[vlc_pkg::C2_ANALOG_LOOPBACK])
        DIGITAL_RX_OUT <= DRIVE_STAGE_IN;
      else
        DIGITAL_RX_OUT <= rx_pol;
      BUS_DRIVE_EN_OUT <= !ctl2[vlc_pkg::C2_ANALOG_LOOPBACK];
    end

  always_comb
  begin
    loop_exit = 1'b0;
    if (wr_ctl2 && ctl2[vlc_pkg::C2_ANALOG_LOOPBACK] && !WDATA_IN[vlc_pkg::C2_ANALOG_LOOPBACK])
      loop_exit = 1'b1;
    if (wr_ctl2 && ctl2[vlc_pkg::C2_DIGITAL_LOOPBACK] && !WDATA_IN[vlc_pkg::C2_DIGITAL_LOOPBACK])
      loop_exit = 1'b1;
  end

  // The guards count idle time only; any bus activity while a guard is
  // running restarts it, so the idle span must be unbroken.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      rx_wait <= 32'h00000000;
      tx_wait <= 32'h00000000;
    end
    else if (loop_exit || !BUS_IDLE_IN)
    begin
      if (loop_exit || rx_wait != 32'h00000000)
        rx_wait <= 32'(END_FRAME_CYCLES);
      if (loop_exit || tx_wait != 32'h00000000)
        tx_wait <= 32'(INTERFRAME_CYCLES);
    end
    else
    begin
      if (rx_wait != 32'h00000000)
        rx_wait <= rx_wait - 32'h00000001;
      if (tx_wait != 32'h00000000)
        tx_wait <= tx_wait - 32'h00000001;
    end

  // Reception waits for the ignore bit and for the idle guard, so a
  // loopback exit cannot pass a frame that was only half seen.
  // Ignore disables reception
  always_comb
  begin
    RX_ENABLE_OUT = 1'b1;
    if (ctl1[vlc_pkg::C1_IGNORE])
      RX_ENABLE_OUT = 1'b0;
    if (rx_wait != 32'h00000000)
      RX_ENABLE_OUT = 1'b0;
  end

  // Transmission is barred in fast mode, in analog loopback and while
  // the inter-frame guard is still counting.
  // Fast mode is receive only
  always_comb
  begin
    TX_ENABLE_OUT = 1'b1;
    if (ctl2[vlc_pkg::C2_FAST_RX])
      TX_ENABLE_OUT = 1'b0;
    if (ctl2[vlc_pkg::C2_ANALOG_LOOPBACK])
      TX_ENABLE_OUT = 1'b0;
    if (tx_wait != 32'h00000000)
      TX_ENABLE_OUT = 1'b0;
  end

  // Status flags elsewhere stay at their reset values while this is high.
  assign STATUS_HOLD_OUT = ctl1[vlc_pkg::C1_IGNORE];
  assign FAST_RX_OUT     = ctl2[vlc_pkg::C2_FAST_RX];

  // A fast symbol outside fast mode is reported as noise and dropped.
  // 4X traffic treated as noise
  always_comb
  begin
    FAST_NOISE_OUT = 1'b0;
    if (FAST_SYMBOL_IN && !ctl2[vlc_pkg::C2_FAST_RX])
      FAST_NOISE_OUT = 1'b1;
  end

  assign FREQ_BINARY_OUT = ctl1[vlc_pkg::C1_FREQ_SEL];

  // The code is unsigned, so the sum spans 9 to 24 and fits five bits.
  // Delay code to microseconds
  assign DELAY_US_OUT    = 5'(vlc_pkg::DELAY_BASE_US) + {1'b0, delay_reg[3:0]};

  // Terminal count of the divider for each rate code; every code is
  // decoded to one of the four rates 1, 2, 4 and 8, so the counter never sticks.
  // Rate divider
  always_comb
  begin
    div_max = 3'h0;
    unique case ({ctl1[vlc_pkg::C1_RATE_HI], ctl1[vlc_pkg::C1_RATE_LO]})
      2'h0: div_max = 3'h0;
      2'h1: div_max = 3'h1;
      2'h2: div_max = 3'h3;
      2'h3: div_max = 3'h7;
    endcase
  end

  // The divider holds its count while the clocks are gated, so the tick
  // phase carries on where it stopped when wait mode ends.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      div_cnt  <= 3'h0;
      TICK_OUT <= 1'b0;
    end
    else if (!CLK_RUN_OUT)
      TICK_OUT <= 1'b0;
    else if (div_cnt >= div_max)
    begin
      div_cnt  <= 3'h0;
      TICK_OUT <= 1'b1;
    end
    else
    begin
      div_cnt  <= div_cnt + 3'h1;
      TICK_OUT <= 1'b0;
    end

  assign CLK_RUN_OUT = !(CPU_WAIT_IN && ctl1[vlc_pkg::C1_WAIT_GATE]);

  // Run-mode request: pending, enabled and not masked by ignore mode.
  // Only code 20 passes ignore
  always_comb
  begin
    irq_run = EVENT_PENDING_IN && ctl1[vlc_pkg::C1_IRQ_EN];
    if (ctl1[vlc_pkg::C1_IGNORE] &&
        STATE_CODE_IN != vlc_pkg::VECTOR_KEEP)
      irq_run = 1'b0;
  end

  // Wake-up requests bypass the enable; run-mode requests follow the
  // pending level, so the line drops once every source is cleared.
  // Enable gates run mode only
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
      IRQ_OUT <= 1'b0;
    else
      IRQ_OUT <= WAKE_REQ_IN || irq_run;

  // Read data stand for the one cycle after the strobe and are zero
  // otherwise, so a late sample reads zero rather than stale data.
  // Delay readable at all times
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
      RDATA_OUT <= 8'h00;
    else if (RD_IN)
    begin
      unique case (ADDR_IN)
        vlc_pkg::ADDR_DELAY:
          RDATA_OUT <= delay_reg;
        vlc_pkg::ADDR_CTL1:
          RDATA_OUT <= ctl1;
        vlc_pkg::ADDR_CTL2:
          RDATA_OUT <= ctl2;
        vlc_pkg::ADDR_STAT:
          RDATA_OUT <= {delay_written, rate_written,
                        RX_ENABLE_OUT, TX_ENABLE_OUT,
                        4'h0};
      endcase
    end
    else
      RDATA_OUT <= 8'h00;

endmodule : vlc_config_regs

// ---- rtl/vlc_pkg.sv ----
package vlc_pkg;
  // Register offsets on the plain register port.
  localparam logic [1:0] ADDR_DELAY = 2'h0;
  localparam logic [1:0] ADDR_CTL1  = 2'h1;
  localparam logic [1:0] ADDR_CTL2  = 2'h2;
  localparam logic [1:0] ADDR_STAT  = 2'h3;
  // Field positions.
  localparam int DLY_XCVR_SEL = 7;
  localparam int DLY_RX_POL   = 6;
  localparam int C1_IGNORE    = 7;
  localparam int C1_FREQ_SEL  = 6;
  localparam int C1_RATE_HI   = 3;
  localparam int C1_RATE_LO   = 2;
  localparam int C1_IRQ_EN    = 1;
  localparam int C1_WAIT_GATE = 0;
  localparam int C2_ANALOG_LOOPBACK     = 7;
  localparam int C2_DIGITAL_LOOPBACK     = 6;
  localparam int C2_FAST_RX   = 5;
  // Reset values and masks.
  localparam logic [7:0] DELAY_RESET = 8'h47;
  localparam logic [7:0] CTL1_RESET  = 8'h00;
  localparam logic [7:0] CTL2_RESET  = 8'h00;
  localparam logic [7:0] DELAY_WMASK = 8'hcf;
  localparam logic [7:0] CTL1_MASK   = 8'hcf;
  localparam logic [7:0] CTL2_MASK   = 8'he0;
  // Delay base, clock rate, link timing and vectors.
  localparam int DELAY_BASE_US  = 9;
  localparam int CLK_MHZ        = 200;
  localparam int END_FRAME_US   = 280;
  localparam int INTERFRAME_US  = 300;
  localparam int END_FRAME_CYC  = END_FRAME_US * CLK_MHZ;
  localparam int INTERFRAME_CYC = INTERFRAME_US * CLK_MHZ;
  localparam logic [15:0] VECTOR_BREAK = 16'h001c;
  localparam logic [7:0]  VECTOR_KEEP  = 8'h20;
endpackage : vlc_pkg

// ---- test/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK_IN = 0, RESETN_IN = 0, WR_IN = 0, RD_IN = 0, TX_DIGITAL_IN = 0;
  logic SOF_SEEN_IN = 0, BREAK_SEEN_IN = 0, FAST_SYMBOL_IN = 0, bus = 1;
  logic BUS_IDLE_IN = 1, EVENT_PENDING_IN = 0, CPU_WAIT_IN = 0, stage = 0;
  logic WAKE_REQ_IN = 0, inv = 0, RX_PIN_IN, DRIVE_STAGE_IN, DIGITAL_RX_OUT;
  logic BUS_DRIVE_EN_OUT, IRQ_OUT, CLK_RUN_OUT, TICK_OUT, FREQ_BINARY_OUT;
  logic RX_ENABLE_OUT, TX_ENABLE_OUT, STATUS_HOLD_OUT, FAST_RX_OUT;
  logic FAST_NOISE_OUT, VECTOR_LOAD_OUT;
  logic [1:0]  ADDR_IN = 2'h0;
  logic [7:0]  WDATA_IN = 8'h00, STATE_CODE_IN = 8'h00, RDATA_OUT, rd_v;
  logic [4:0]  DELAY_US_OUT;
  logic [15:0] VECTOR_VALUE_OUT;
  int          fail_count = 0, checks = 0;
  logic [18:0] rows [9] = '{{1'h0,2'h0,8'h00,8'h47}, {1'h0,2'h1,8'h00,8'h00},
    {1'h0,2'h2,8'h00,8'h00}, {1'h1,2'h0,8'h4a,8'h4a}, {1'h1,2'h0,8'h05,8'h4a},
    {1'h1,2'h1,8'h45,8'h45}, {1'h1,2'h1,8'h42,8'h46}, {1'h1,2'h2,8'hff,8'he0},
    {1'h1,2'h2,8'h00,8'h00}};
  vlc_config_regs #(.END_FRAME_CYCLES(20), .INTERFRAME_CYCLES(30)) dut (.*);
  vlc_xcvr_model xcvr (.bus_in(bus), .drive_in(stage), .invert_in(inv),
    .rx_pin_out(RX_PIN_IN), .echo_out(DRIVE_STAGE_IN));
  always #2.5 CLK_IN = ~CLK_IN;
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task cyc(input int n);
    repeat (n) @(posedge CLK_IN);
    #1;
  endtask : cyc
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge CLK_IN);
    {ADDR_IN, WDATA_IN, WR_IN} <= {a, d, 1'h1};
    @(posedge CLK_IN);
    WR_IN <= 1'h0;
  endtask : wr
  task rd(input logic [1:0] a);
    @(posedge CLK_IN);
    {ADDR_IN, RD_IN} <= {a, 1'h1};
    @(posedge CLK_IN);
    RD_IN <= 1'h0;
    #1 rd_v = RDATA_OUT;
  endtask : rd
  task pulse(input logic [2:0] p);
    @(posedge CLK_IN);
    {SOF_SEEN_IN, BREAK_SEEN_IN, FAST_SYMBOL_IN} <= p;
    @(posedge CLK_IN);
    {SOF_SEEN_IN, BREAK_SEEN_IN, FAST_SYMBOL_IN} <= 3'h0;
  endtask : pulse
  task rx_chk(input logic t, input logic s, input logic p, input logic e);
    @(posedge CLK_IN);
    {TX_DIGITAL_IN, stage, bus} <= {t, s, p};
    cyc(5);
    chk("digital_rx", 16'(e), 16'(DIGITAL_RX_OUT));
  endtask : rx_chk
  task idle_chk;
    cyc(3);
    chk("rx_en_early", 16'h0000, 16'(RX_ENABLE_OUT));
    cyc(22);
    chk("rx_en", 16'h0001, 16'(RX_ENABLE_OUT));
    chk("tx_en_early", 16'h0000, 16'(TX_ENABLE_OUT));
    cyc(15);
    chk("tx_en", 16'h0001, 16'(TX_ENABLE_OUT));
  endtask : idle_chk
  task tick_chk(input int e);
    int c;
    c = 0;
    repeat (16) begin @(posedge CLK_IN); #1 c += int'(TICK_OUT); end
    chk("ticks", 16'(e), 16'(c));
  endtask : tick_chk
  initial
  begin
    #20000 fail_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (4) @(posedge CLK_IN);
    RESETN_IN <= 1'h1;
    foreach (rows[i])
    begin
      if (rows[i][18]) wr(rows[i][17:16], rows[i][15:8]);
      rd(rows[i][17:16]);
      chk("rdata", {8'h00, rows[i][7:0]}, {8'h00, rd_v});
    end
    chk("delay", 16'h0013, 16'(DELAY_US_OUT));
    chk("freq", 16'h0001, 16'(FREQ_BINARY_OUT));
    tick_chk(8);
    rx_chk(1'h1, 1'h1, 1'h0, 1'h0);
    rx_chk(1'h0, 1'h0, 1'h1, 1'h1);
    wr(2'h2, 8'h40);
    rx_chk(1'h1, 1'h0, 1'h0, 1'h1);
    rx_chk(1'h0, 1'h1, 1'h1, 1'h0);
    wr(2'h2, 8'h00);
    idle_chk();
    rx_chk(1'h0, 1'h0, 1'h1, 1'h1);
    wr(2'h2, 8'h80);
    rx_chk(1'h0, 1'h1, 1'h0, 1'h1);
    chk("drive_en", 16'h0000, 16'(BUS_DRIVE_EN_OUT));
    wr(2'h2, 8'h00);
    idle_chk();
    chk("drive_en", 16'h0001, 16'(BUS_DRIVE_EN_OUT));
    @(posedge CLK_IN);
    EVENT_PENDING_IN <= 1'h1;
    cyc(3);
    chk("irq", 16'h0001, 16'(IRQ_OUT));
    wr(2'h1, 8'hc6);
    cyc(3);
    chk("irq", 16'h0000, 16'(IRQ_OUT));
    chk("hold", 16'h0001, 16'(STATUS_HOLD_OUT));
    @(posedge CLK_IN);
    STATE_CODE_IN <= 8'h20;
    cyc(3);
    chk("irq", 16'h0001, 16'(IRQ_OUT));
    pulse(3'h4);
    STATE_CODE_IN <= 8'h00;
    rd(2'h1);
    chk("ctl1", 16'h0046, {8'h00, rd_v});
    cyc(2);
    chk("irq", 16'h0001, 16'(IRQ_OUT));
    @(posedge CLK_IN);
    EVENT_PENDING_IN <= 1'h0;
    cyc(3);
    chk("irq", 16'h0000, 16'(IRQ_OUT));
    wr(2'h1, 8'h45);
    {EVENT_PENDING_IN, CPU_WAIT_IN} <= 2'h3;
    cyc(3);
    chk("irq", 16'h0000, 16'(IRQ_OUT));
    chk("clk_run", 16'h0000, 16'(CLK_RUN_OUT));
    @(posedge CLK_IN);
    WAKE_REQ_IN <= 1'h1;
    cyc(3);
    chk("irq", 16'h0001, 16'(IRQ_OUT));
    @(posedge CLK_IN);
    {WAKE_REQ_IN, EVENT_PENDING_IN, CPU_WAIT_IN} <= 3'h0;
    wr(2'h1, 8'hc4);
    wr(2'h2, 8'h20);
    cyc(2);
    chk("fast", 16'h0001, 16'(FAST_RX_OUT));
    pulse(3'h1);
    pulse(3'h2);
    pulse(3'h1);
    rd(2'h2);
    chk("ctl2", 16'h0000, {8'h00, rd_v});
    chk("hold", 16'h0000, 16'(STATUS_HOLD_OUT));
    @(posedge CLK_IN);
    RESETN_IN <= 1'h0;
    cyc(4);
    chk("delay", 16'h0010, 16'(DELAY_US_OUT));
    @(posedge CLK_IN);
    RESETN_IN <= 1'h1;
    wr(2'h0, 8'h03);
    rd(2'h0);
    chk("delay_reg", 16'h0003, {8'h00, rd_v});
    @(posedge CLK_IN);
    inv <= 1'h1;
    rx_chk(1'h0, 1'h0, 1'h1, 1'h1);
    tick_chk(16);
    tally_and_finish();
  end
endmodule : tb

// ---- test/vlc_regs_sva.sv ----
module vlc_regs_sva (
  input wire logic        CLK_IN,
  input wire logic        RESETN_IN,
  input wire logic [1:0]  ADDR_IN,
  input wire logic        RD_IN,
  input wire logic [7:0]  RDATA_OUT,
  input wire logic        SOF_SEEN_IN,
  input wire logic        BREAK_SEEN_IN,
  input wire logic        FAST_SYMBOL_IN,
  input wire logic        EVENT_PENDING_IN,
  input wire logic        CPU_WAIT_IN,
  input wire logic        WAKE_REQ_IN,
  input wire logic        IRQ_OUT,
  input wire logic        CLK_RUN_OUT,
  input wire logic        FREQ_BINARY_OUT,
  input wire logic [4:0]  DELAY_US_OUT,
  input wire logic        STATUS_HOLD_OUT,
  input wire logic        FAST_RX_OUT,
  input wire logic        FAST_NOISE_OUT,
  input wire logic        VECTOR_LOAD_OUT,
  input wire logic [15:0] VECTOR_VALUE_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  dly_map_a: assert property (RD_IN && ADDR_IN == 2'h0 |=>
    RDATA_OUT[3:0] + 5'h09 == DELAY_US_OUT) else $error("delay map");
  freq_sel_a: assert property (RD_IN && ADDR_IN == 2'h1 |=>
    FREQ_BINARY_OUT == RDATA_OUT[6]) else $error("freq select");
  vec_load_a: assert property (BREAK_SEEN_IN |=> VECTOR_LOAD_OUT)
    else $error("vector load");
  vec_val_a: assert property (VECTOR_LOAD_OUT |->
    VECTOR_VALUE_OUT == 16'h001c) else $error("vector value");
  fast_clr_a: assert property (BREAK_SEEN_IN |=> !FAST_RX_OUT)
    else $error("fast not cleared");
  ign_clr_a: assert property (SOF_SEEN_IN || BREAK_SEEN_IN |=>
    !STATUS_HOLD_OUT) else $error("ignore not cleared");
  noise_a: assert property (FAST_NOISE_OUT ==
    (FAST_SYMBOL_IN && !FAST_RX_OUT)) else $error("fast noise");
  wake_irq_a: assert property (WAKE_REQ_IN |=> IRQ_OUT)
    else $error("wake irq");
  irq_drop_a: assert property (!EVENT_PENDING_IN && !WAKE_REQ_IN
    |=> !IRQ_OUT) else $error("irq without source");
  clk_run_a: assert property (!CPU_WAIT_IN |-> CLK_RUN_OUT)
    else $error("clock stopped");
  cover property (BREAK_SEEN_IN ##1 VECTOR_LOAD_OUT);
  cover property (WAKE_REQ_IN ##1 IRQ_OUT);
  cover property (STATUS_HOLD_OUT ##1 !STATUS_HOLD_OUT);
endmodule : vlc_regs_sva
bind vlc_config_regs vlc_regs_sva sva_i (.*);

// ---- test/vlc_xcvr_model.sv ----
module vlc_xcvr_model (
  input  wire logic bus_in,     // Bus level
  input  wire logic drive_in,   // Final stage input
  input  wire logic invert_in,  // Transceiver inverts
  output logic      rx_pin_out, // Receive pin
  output logic      echo_out    // Stage echo
);
  timeunit 1ns;
  timeprecision 100ps;
  assign rx_pin_out = bus_in ^ invert_in;
  assign echo_out = drive_in;
endmodule : vlc_xcvr_model
